// File: hbp_defs.svh
// constants for the host bus and buffer ram port
// Notes on behaviour
// - open-drain async ready pulls low to stretch; release timed by crystal tick.
// - in local-bus mode sync ready idles high; rising edge on local clock completes.
// - burst cycles wait until ready return is sampled high on a falling local edge.
// - only the selected one of four interrupt pins is driven; others float.
// - local device output is a combinational decode of unlatched qualifier and address.
// - data path select low grants packet data path, 32 bits per beat.
// - ram reads are always full doublewords; writes use per-byte strobes.
// - with status float set, low data byte floats on receive status word write.
// - ram address output carries the doubleword index being accessed.
// - active-low ram read enable reads one doubleword.
// - four active-low byte write strobes allow byte, word or doubleword writes.
// - receive-write indication is active only on received data writes.
// - core timing comes from a 25 MHz crystal rate.
// - bus-type input low selects local-bus mode, high selects burst mode.
// - byte lanes are ignored, 32-bit transfers assumed, when data path is selected.
// - address decoding is enabled only while the qualifier is low.
// - address and qualifier are latched on the rising edge of the address strobe.
`ifndef HBP_DEFS_SVH
`define HBP_DEFS_SVH
`define CLK_HZ 100_000_000
`define XTAL_HZ 25_000_000
`define XTAL_DIV (`CLK_HZ / `XTAL_HZ)
`define RAM_PULSE 4
`define REG_CONFIG 12'h000
`define REG_BASE 12'h004
`define REG_PTR 12'h008
`define REG_IRQ_STATUS 12'h00c
`define REG_IRQ_CLEAR 12'h010
`define REG_IRQ_ENABLE 12'h014
`define REG_PIN_STATE 12'h018
`define CFG_INT_SEL 1:0
`define CFG_FLOAT 2
`define CFG_RESET 3'h0
`define BASE_RESET 16'h0300
`define EV_RX 0
`define EV_HOST 1
`define EV_W 2
`endif

// File: hbp_pkg.sv
// types shared by the host bus and buffer ram port
package hbp_pkg;
   typedef struct packed {
      logic valid;
      logic write;
      logic rx;
      logic [14:0] addr;
      logic [3:0] lane_n;
      logic [31:0] data;
   } ram_req_type;
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_RAM = 7'h02,
      ST_ASYNC_REL = 7'h04,
      ST_ASYNC_END = 7'h08,
      ST_LB_ACK = 7'h10,
      ST_LB_HOLD = 7'h20,
      ST_BURST_RTN = 7'h40
   } host_state_type;
endpackage

// File: sync_bank.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module sync_bank #(parameter int W = 1) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] q_q;
   // no reset: the flops hold the idle pin levels as reset lifts, so no false strobe
   always_ff @(posedge mclk) begin
      meta_q <= d;
      q_q <= meta_q;
   end
   assign q = q_q;
endmodule // sync_bank

// File: ram_port.sv
// buffer sram cycle engine: one doubleword read or byte-strobed write
`timescale 1ns/1ps
`include "hbp_defs.svh"
module ram_port import hbp_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   input ram_req_type req,
   input wire logic float_en,
   output logic ready,
   output logic done,
   output logic [31:0] rdata,
   output logic [14:0] ram_addr,
   output logic ram_read_en_n,
   output logic [3:0] ram_byte_write_n,
   input wire logic [31:0] ram_data_i,
   output logic [31:0] ram_data_o,
   output logic [3:0] ram_data_oe,
   output logic rx_buffer_write_active
);
   ram_req_type op_q, op_d;
   logic busy_q, busy_d, done_q, done_d;
   logic [2:0] cnt_q, cnt_d;
   logic [31:0] rdata_q, rdata_d, data_s;
   logic last, flt;
   sync_bank #(.W(32)) u_rd_sync (.mclk(mclk), .rst_n(rst_n), .d(ram_data_i), .q(data_s));
   assign ready = !busy_q;
   assign last = busy_q && (cnt_q == 3'(`RAM_PULSE - 1));
   // status word at index zero, all lanes, receive write
   assign flt = float_en && op_q.rx && op_q.write && (op_q.addr == 15'h0000)
      && (op_q.lane_n == 4'h0);
   always_comb begin
      op_d = op_q;
      busy_d = busy_q;
      cnt_d = cnt_q;
      done_d = 1'b0;
      rdata_d = rdata_q;
      if (!busy_q && req.valid) begin
         op_d = req;
         busy_d = 1'b1;
         cnt_d = 3'h0;
      end else if (last) begin
         busy_d = 1'b0;
         done_d = 1'b1;
         // synced copy lags two cycles, still inside the strobe here
         if (!op_q.write)
            rdata_d = data_s;
      end else if (busy_q) begin
         cnt_d = cnt_q + 3'h1;
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         op_q <= '0;
         busy_q <= 1'b0;
         cnt_q <= 3'h0;
         done_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         op_q <= op_d;
         busy_q <= busy_d;
         cnt_q <= cnt_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end
   assign done = done_q;
   assign rdata = rdata_q;
   assign ram_addr = op_q.addr;
   assign ram_read_en_n = !(busy_q && !op_q.write);
   assign ram_byte_write_n = (busy_q && op_q.write) ? op_q.lane_n : 4'hf;
   assign ram_data_o = op_q.data;
   assign ram_data_oe = (busy_q && op_q.write) ? {3'h7, !flt} : 4'h0;
   assign rx_buffer_write_active = busy_q && op_q.write && op_q.rx;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_read_full_word: assert property (!ram_read_en_n |-> ram_byte_write_n == 4'hf && ram_data_oe == 4'h0)
      else $error("read cycle drives strobes or data");
   a_read_pulse_len: assert property ($fell(ram_read_en_n) |-> !ram_read_en_n[*4] ##1 ram_read_en_n)
      else $error("read enable width wrong");
   a_status_float: assert property (busy_q && flt |-> !ram_data_oe[0] && ram_data_oe[3:1] == 3'h7)
      else $error("status byte not floated");
   a_rx_only_write: assert property (rx_buffer_write_active |-> ram_read_en_n && op_q.rx)
      else $error("receive indication outside receive write");
endmodule // ram_port

// File: host_bus_port.sv
// host bus handshake, decode, interrupt pins and buffer ram port
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "hbp_defs.svh"
module host_bus_port import hbp_pkg::*; (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:4] host_addr,
   input wire logic addr_qualifier,
   input wire logic addr_latch_strobe_n,
   input wire logic async_read_strobe_n,
   input wire logic async_write_strobe_n,
   input wire logic burst_cycle_n,
   input wire logic sync_write,
   input wire logic local_bus_mode_n,
   input wire logic lclk,
   input wire logic ready_return_n,
   input wire logic data_path_select_n,
   input wire logic [3:0] host_byte_lane_n,
   input wire logic [31:0] host_data_i,
   output logic [31:0] host_data_o,
   output logic host_data_oe,
   output logic async_ready_n_o,
   output logic async_ready_n_oe,
   output logic sync_ready_n,
   output logic local_device_n,
   output logic [3:0] irq_outputs,
   output logic [3:0] irq_outputs_oe,
   input wire logic rx_word_valid,
   input wire logic [31:0] rx_word,
   input wire logic rx_status_valid,
   input wire logic [31:0] rx_status,
   output logic rx_ready,
   output logic [14:0] ram_addr,
   output logic ram_read_en_n,
   output logic [3:0] ram_byte_write_n,
   input wire logic [31:0] ram_data_i,
   output logic [31:0] ram_data_o,
   output logic [3:0] ram_data_oe,
   output logic rx_buffer_write_active
);
   localparam int SW = 58;
   logic [SW-1:0] pins_s;
   logic s_lclk, s_ads_n, s_rd_n, s_wr_n, s_cyc_n, s_wdir, s_lbm_n, s_rtn_n, s_dps_n, s_aq;
   logic [15:4] s_addr;
   logic [3:0] s_lane_n;
   logic [31:0] s_data;
   sync_bank #(.W(SW)) u_pin_sync (.mclk(mclk), .rst_n(rst_n),
      .d({lclk, addr_latch_strobe_n, async_read_strobe_n, async_write_strobe_n, burst_cycle_n,
          sync_write, local_bus_mode_n, ready_return_n, data_path_select_n, addr_qualifier,
          host_addr, host_byte_lane_n, host_data_i}),
      .q(pins_s));
   assign {s_lclk, s_ads_n, s_rd_n, s_wr_n, s_cyc_n, s_wdir, s_lbm_n, s_rtn_n, s_dps_n, s_aq,
           s_addr, s_lane_n, s_data} = pins_s;

   function automatic logic base_hit(input logic aq, input logic [15:4] a, input logic [15:0] b);
      base_hit = !aq && (a == b[15:4]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // crystal-rate tick: one clock only, so the 25 MHz rate is an enable
   logic [1:0] xcnt_q, xcnt_d;
   logic xtal_tick;
   assign xtal_tick = (xcnt_q == 2'(`XTAL_DIV - 1));
   always_comb xcnt_d = xtal_tick ? 2'h0 : xcnt_q + 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [2:0] cfg_q, cfg_d;
   logic [15:0] base_q, base_d;
   logic [14:0] ptr_q, ptr_d;
   logic [`EV_W-1:0] ist_q, ist_d, ien_q, ien_d, ev;
   logic [31:0] prdata_q, prdata_d;
   logic wr_acc, mapped, ptr_step;
   assign wr_acc = psel && penable && pwrite;
   assign mapped = paddr inside {`REG_CONFIG, `REG_BASE, `REG_PTR, `REG_IRQ_STATUS,
      `REG_IRQ_CLEAR, `REG_IRQ_ENABLE, `REG_PIN_STATE};
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   always_comb begin
      cfg_d = cfg_q;
      base_d = base_q;
      ptr_d = ptr_step ? ptr_q + 15'h0001 : ptr_q;
      ien_d = ien_q;
      // a new event wins over a clear in the same cycle
      ist_d = ist_q;
      if (wr_acc && paddr == `REG_IRQ_CLEAR)
         ist_d = ist_q & ~pwdata[`EV_W-1:0];
      ist_d = ist_d | ev;
      if (wr_acc) begin
         unique case (paddr)
            `REG_CONFIG: cfg_d = pwdata[2:0];
            `REG_BASE: base_d = pwdata[15:0];
            `REG_PTR: ptr_d = pwdata[14:0];
            `REG_IRQ_ENABLE: ien_d = pwdata[`EV_W-1:0];
            default: ;
         endcase
      end
      prdata_d = prdata_q;
      if (psel && !penable) begin
         unique case (paddr)
            `REG_CONFIG: prdata_d = {29'h0000_0000, cfg_q};
            `REG_BASE: prdata_d = {16'h0000, base_q};
            `REG_PTR: prdata_d = {17'h0_0000, ptr_q};
            `REG_IRQ_STATUS: prdata_d = {30'h0000_0000, ist_q};
            `REG_IRQ_ENABLE: prdata_d = {30'h0000_0000, ien_q};
            `REG_PIN_STATE: prdata_d = {29'h0000_0000, s_lbm_n, s_dps_n, async_ready_n_oe};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
   end
   assign prdata = prdata_q;

   // only the selected pin drives the interrupt level
   logic irq;
   assign irq = |(ist_q & ien_q);
   generate
      for (genvar i = 0; i < 4; i++) begin : g_irq
         assign irq_outputs[i] = irq;
         assign irq_outputs_oe[i] = (cfg_q[`CFG_INT_SEL] == 2'(i));
      end
   endgenerate

   // decode straight from the pins, no latch or synchroniser
   assign local_device_n = !base_hit(addr_qualifier, host_addr, base_q);

   ////////////////////////////////////////////////////////////////////////////
   // host cycle sequencer
   host_state_type st_q, st_d;
   logic lclk_p_q, ads_p_q, hit_q, hit_d, async_q, async_d, burst_q, burst_d, dp_q, dp_d;
   logic rd_q, rd_d, arl_q, arl_d, srl_q, srl_d;
   logic [31:0] hdata_q, hdata_d;
   logic lclk_rise, lclk_fall, dp, sel, a_start, s_start, ram_ready, ram_done;
   logic [31:0] ram_rdata;
   ram_req_type req, host_req;
   logic [14:0] rx_ptr_q, rx_ptr_d;
   logic rx_want;

   assign lclk_rise = s_lclk && !lclk_p_q;
   assign lclk_fall = !s_lclk && lclk_p_q;
   assign dp = !s_dps_n;
   assign sel = dp || hit_q;
   assign a_start = (!s_rd_n || !s_wr_n) && sel;
   // burst mode needs the data path, local-bus mode takes any decoded cycle
   assign s_start = lclk_rise && !s_cyc_n && (s_lbm_n ? dp : sel);
   assign rx_want = rx_word_valid || rx_status_valid;
   assign rx_ready = ram_ready;

   always_comb begin
      st_d = st_q;
      hit_d = hit_q;
      async_d = async_q;
      burst_d = burst_q;
      dp_d = dp_q;
      rd_d = rd_q;
      arl_d = arl_q;
      srl_d = srl_q;
      hdata_d = hdata_q;
      host_req = '0;
      ptr_step = 1'b0;
      ev = '0;
      ev[`EV_RX] = rx_status_valid && ram_ready;
      if (ads_p_q == 1'b0 && s_ads_n)
         hit_d = base_hit(s_aq, s_addr, base_q);
      host_req.addr = ptr_q;
      host_req.data = s_data;
      host_req.lane_n = dp ? 4'h0 : s_lane_n;
      unique case (st_q)
         ST_IDLE: begin
            host_req.write = a_start ? !s_wr_n : s_wdir;
            if ((a_start || s_start) && ram_ready && !rx_want) begin
               host_req.valid = 1'b1;
               async_d = a_start;
               burst_d = !a_start && s_lbm_n;
               dp_d = dp;
               rd_d = !host_req.write;
               arl_d = a_start;
               st_d = ST_RAM;
            end
         end
         ST_RAM: begin
            if (ram_done) begin
               if (rd_q)
                  hdata_d = ram_rdata;
               ptr_step = dp_q;
               st_d = async_q ? ST_ASYNC_REL : (burst_q ? ST_BURST_RTN : ST_LB_ACK);
            end
         end
         ST_ASYNC_REL: begin
            if (xtal_tick) begin
               arl_d = 1'b0;
               st_d = ST_ASYNC_END;
            end
         end
         ST_ASYNC_END: begin
            if (s_rd_n && s_wr_n) begin
               ev[`EV_HOST] = 1'b1;
               st_d = ST_IDLE;
            end
         end
         ST_LB_ACK: begin
            if (lclk_rise) begin
               srl_d = 1'b1;
               st_d = ST_LB_HOLD;
            end
         end
         ST_LB_HOLD: begin
            if (lclk_rise) begin
               srl_d = 1'b0;
               ev[`EV_HOST] = 1'b1;
               st_d = ST_IDLE;
            end
         end
         ST_BURST_RTN: begin
            // the return pin ends the cycle once a falling local edge sees it high
            if (lclk_fall && s_rtn_n) begin
               ev[`EV_HOST] = 1'b1;
               st_d = ST_IDLE;
            end
         end
      endcase
   end

   // receive data has priority over the host so the mac never overruns
   always_comb begin
      rx_ptr_d = rx_ptr_q;
      req = host_req;
      if (rx_want && ram_ready) begin
         req = '0;
         req.valid = 1'b1;
         req.write = 1'b1;
         req.rx = 1'b1;
         if (rx_status_valid) begin
            req.data = rx_status;
            rx_ptr_d = 15'h0001;
         end else begin
            req.addr = rx_ptr_q;
            req.data = rx_word;
            rx_ptr_d = rx_ptr_q + 15'h0001;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         xcnt_q <= 2'h0;
         cfg_q <= `CFG_RESET;
         base_q <= `BASE_RESET;
         ptr_q <= 15'h0000;
         ist_q <= '0;
         ien_q <= '0;
         prdata_q <= 32'h0000_0000;
         st_q <= ST_IDLE;
         lclk_p_q <= 1'b0;
         ads_p_q <= 1'b1;
         hit_q <= 1'b0;
         async_q <= 1'b0;
         burst_q <= 1'b0;
         dp_q <= 1'b0;
         rd_q <= 1'b0;
         arl_q <= 1'b0;
         srl_q <= 1'b0;
         hdata_q <= 32'h0000_0000;
         rx_ptr_q <= 15'h0001;
      end else begin
         xcnt_q <= xcnt_d;
         cfg_q <= cfg_d;
         base_q <= base_d;
         ptr_q <= ptr_d;
         ist_q <= ist_d;
         ien_q <= ien_d;
         prdata_q <= prdata_d;
         st_q <= st_d;
         lclk_p_q <= s_lclk;
         ads_p_q <= s_ads_n;
         hit_q <= hit_d;
         async_q <= async_d;
         burst_q <= burst_d;
         dp_q <= dp_d;
         rd_q <= rd_d;
         arl_q <= arl_d;
         srl_q <= srl_d;
         hdata_q <= hdata_d;
         rx_ptr_q <= rx_ptr_d;
      end
   end

   assign async_ready_n_o = 1'b0;
   assign async_ready_n_oe = arl_q;
   assign sync_ready_n = !srl_q;
   assign host_data_o = hdata_q;
   assign host_data_oe = rd_q && (st_q != ST_IDLE) && (st_q != ST_RAM);

   ram_port u_ram (.mclk(mclk), .rst_n(rst_n), .req(req), .float_en(cfg_q[`CFG_FLOAT]),
      .ready(ram_ready), .done(ram_done), .rdata(ram_rdata), .ram_addr(ram_addr),
      .ram_read_en_n(ram_read_en_n), .ram_byte_write_n(ram_byte_write_n),
      .ram_data_i(ram_data_i), .ram_data_o(ram_data_o), .ram_data_oe(ram_data_oe),
      .rx_buffer_write_active(rx_buffer_write_active));

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence srdy_ack;
      $fell(sync_ready_n) ##0 $past(lclk_rise);
   endsequence
   sequence srdy_hold;
      !sync_ready_n [*1] ##0 !lclk_rise;
   endsequence
   a_async_release: assert property ($fell(async_ready_n_oe) |-> $past(xtal_tick))
      else $error("async ready released off the crystal tick");
   a_srdy_edge: assert property ($fell(sync_ready_n) |-> srdy_ack)
      else $error("sync ready fell off a local clock edge");
   a_srdy_mode: assert property (!sync_ready_n |-> !burst_q && !async_q)
      else $error("sync ready used outside local-bus cycle");
   a_burst_wait: assert property (st_q == ST_BURST_RTN && !(lclk_fall && s_rtn_n) |=> st_q == ST_BURST_RTN)
      else $error("burst cycle ended before ready return");
   a_irq_one_pin: assert property ($onehot(irq_outputs_oe) && irq_outputs_oe[cfg_q[1:0]])
      else $error("interrupt pin select wrong");
   a_ldev_decode: assert property (!local_device_n == (!addr_qualifier && host_addr == base_q[15:4]))
      else $error("local device decode wrong");
   a_dp_lanes: assert property (host_req.valid && dp |-> host_req.lane_n == 4'h0)
      else $error("data path beat not 32 bits");
   a_xtal_rate: assert property (xtal_tick |=> !xtal_tick [*3] ##1 xtal_tick)
      else $error("crystal tick rate wrong");
   a_burst_mode: assert property (st_q == ST_IDLE && st_d == ST_RAM && !a_start |-> burst_d == s_lbm_n)
      else $error("bus mode not taken from bus-type input");
endmodule // host_bus_port

// File: sram_model.sv
// behavioural buffer sram with pulled-up data lines
`timescale 1ns/1ps
module sram_model (
   input wire logic mclk,
   input wire logic [14:0] ram_addr,
   input wire logic ram_read_en_n,
   input wire logic [3:0] ram_byte_write_n,
   input wire logic [31:0] ram_data_o,
   input wire logic [3:0] ram_data_oe,
   input wire logic rx_buffer_write_active,
   output logic [31:0] ram_data_i
);
   logic [31:0] mem [0:32767];
   logic [31:0] bus;
   logic last_rx;
   initial last_rx = 1'b0;
   // an undriven byte lane floats up to ones through the pull-ups
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         bus[i*8 +: 8] = ram_data_oe[i] ? ram_data_o[i*8 +: 8] : 8'hff;
      end
   end
   // whole doubleword read at the addressed index
   assign ram_data_i = !ram_read_en_n ? mem[ram_addr] : 32'hffff_ffff;
   always @(posedge mclk) begin
      if (ram_byte_write_n != 4'hf) begin
         for (int i = 0; i < 4; i++) begin
            // per-lane write strobes
            if (!ram_byte_write_n[i]) mem[ram_addr][i*8 +: 8] <= bus[i*8 +: 8];
         end
         last_rx <= rx_buffer_write_active;
      end
   end
endmodule // sram_model

// File: host_bus_port_tb.sv
// self-checking bench for the host bus and buffer ram port
`timescale 1ns/1ps
`include "hbp_defs.svh"
module host_bus_port_tb;
   import hbp_pkg::*;
   logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 0, host_addr = 0;
   logic [31:0] pwdata = 0, prdata, host_data_i = 0, host_data_o, ram_data_i, ram_data_o;
   logic addr_qualifier = 1, addr_latch_strobe_n = 1, async_read_strobe_n = 1, async_write_strobe_n = 1;
   logic local_bus_mode_n = 1, data_path_select_n = 1, rx_status_valid = 0, rx_ready;
   logic lclk = 0, burst_cycle_n = 1, ready_return_n = 1, lclk_run = 0;
   logic [1:0] lcnt = 2'h0;
   logic [3:0] host_byte_lane_n = 4'hf, irq_outputs, irq_outputs_oe, ram_byte_write_n, ram_data_oe;
   logic host_data_oe, async_ready_n_o, async_ready_n_oe, sync_ready_n, local_device_n;
   logic [14:0] ram_addr;
   logic ram_read_en_n, rx_buffer_write_active;
   logic [31:0] rd;
   logic se;
   int err_count = 0, checks_done = 0, cycles = 0;
   always #5 mclk = ~mclk;
   host_bus_port host_bus_port_inst (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .host_addr(host_addr), .addr_qualifier(addr_qualifier),
      .addr_latch_strobe_n(addr_latch_strobe_n), .async_read_strobe_n(async_read_strobe_n),
      .async_write_strobe_n(async_write_strobe_n), .burst_cycle_n(burst_cycle_n), .sync_write(1'b0),
      .local_bus_mode_n(local_bus_mode_n), .lclk(lclk), .ready_return_n(ready_return_n),
      .data_path_select_n(data_path_select_n), .host_byte_lane_n(host_byte_lane_n),
      .host_data_i(host_data_i), .host_data_o(host_data_o), .host_data_oe(host_data_oe),
      .async_ready_n_o(async_ready_n_o), .async_ready_n_oe(async_ready_n_oe),
      .sync_ready_n(sync_ready_n), .local_device_n(local_device_n), .irq_outputs(irq_outputs),
      .irq_outputs_oe(irq_outputs_oe), .rx_word_valid(1'b0), .rx_word(32'h0000_0000),
      .rx_status_valid(rx_status_valid), .rx_status(32'h1234_5a3c), .rx_ready(rx_ready),
      .ram_addr(ram_addr), .ram_read_en_n(ram_read_en_n), .ram_byte_write_n(ram_byte_write_n),
      .ram_data_i(ram_data_i), .ram_data_o(ram_data_o), .ram_data_oe(ram_data_oe),
      .rx_buffer_write_active(rx_buffer_write_active));
   sram_model sram_model_inst (.mclk(mclk), .ram_addr(ram_addr), .ram_read_en_n(ram_read_en_n),
      .ram_byte_write_n(ram_byte_write_n), .ram_data_o(ram_data_o), .ram_data_oe(ram_data_oe),
      .rx_buffer_write_active(rx_buffer_write_active), .ram_data_i(ram_data_i));
   ////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // local clock, eight mclk a period, runs only inside sync tests and parks low
   always @(posedge mclk) begin
      if (lclk_run || lclk) begin
         lcnt <= lcnt + 2'h1;
         if (lcnt == 2'h3) lclk <= ~lclk;
      end
   end
   // ceiling is far above the few hundred cycles the scenarios need
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // async host cycle: strobe held until the stretched ready is released
   task host_cycle(input logic w, input logic [31:0] d);
      int n;
      @(posedge mclk);
      host_data_i <= d;
      if (w) async_write_strobe_n <= 0;
      else async_read_strobe_n <= 0;
      n = 0;
      do begin @(posedge mclk); n++; end while (async_ready_n_oe !== 1'b1 && n < 50);
      chk("ready_pulled_low", 1, async_ready_n_oe);
      n = 0;
      do begin @(posedge mclk); n++; end while (async_ready_n_oe !== 1'b0 && n < 50);
      chk("ready_released", 0, async_ready_n_oe);
      chk("ready_level", 0, async_ready_n_o);
      chk("host_oe", !w, host_data_oe);
      rd = host_data_o;
      async_write_strobe_n <= 1;
      async_read_strobe_n <= 1;
      repeat (3) @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task test_reset_and_mode;
      chk("irq_oe_reset", 4'b0001, irq_outputs_oe);
      chk("sync_ready_idle", 1, sync_ready_n);
      chk("ram_idle", 5'h1f, {ram_read_en_n, ram_byte_write_n});
      apb(0, `REG_PIN_STATE, 0);
      chk("pin_state", 3'b110, rd[2:0]);
      apb(0, 12'h0f0, 0);
      chk("unmapped_err", 1, se);
      chk("unmapped_rd", 0, rd);
   endtask
   task test_irq_select;
      for (int i = 0; i < 4; i++) begin
         apb(1, `REG_CONFIG, i);
         @(posedge mclk);
         chk("irq_oe_sel", 4'b0001 << i, irq_outputs_oe);
      end
   endtask
   task test_decode;
      apb(0, `REG_BASE, 0);
      chk("base_reset", 32'h0000_0300, rd);
      host_addr <= 12'h030;
      addr_qualifier <= 0;
      @(posedge mclk);
      chk("ldev_hit", 0, local_device_n);
      addr_qualifier <= 1;
      @(posedge mclk);
      chk("ldev_no_qual", 1, local_device_n);
      host_addr <= 12'h031;
      addr_qualifier <= 0;
      @(posedge mclk);
      chk("ldev_miss", 1, local_device_n);
      host_addr <= 12'h030;
      addr_latch_strobe_n <= 0;
      @(posedge mclk);
      addr_latch_strobe_n <= 1;
      repeat (4) @(posedge mclk);
      host_addr <= 12'h031;
      addr_qualifier <= 1;
      host_byte_lane_n <= 4'b1110;
      apb(1, `REG_PTR, 9);
      host_cycle(1, 32'hffff_ff42);
      chk("latched_lane", 32'h42, sram_model_inst.mem[9][7:0]);
   endtask
   task test_sync_cycles;
      int n;
      local_bus_mode_n <= 0;
      data_path_select_n <= 0;
      ready_return_n <= 0;
      apb(1, `REG_PTR, 5);
      burst_cycle_n <= 0;
      lclk_run <= 1;
      n = 0;
      do begin @(posedge mclk); n++; end while (sync_ready_n !== 1'b0 && n < 200);
      burst_cycle_n <= 1;
      chk("lb_ready", 0, sync_ready_n);
      chk("lb_on_rise", 1, lclk);
      chk("lb_read", 32'ha5a5_1234, host_data_o);
      n = 0;
      do begin @(posedge mclk); n++; end while (sync_ready_n !== 1'b1 && n < 200);
      chk("lb_ready_end", 1, sync_ready_n);
      local_bus_mode_n <= 1;
      burst_cycle_n <= 0;
      n = 0;
      do begin @(posedge mclk); n++; end while (host_data_oe !== 1'b1 && n < 200);
      burst_cycle_n <= 1;
      chk("burst_read", 32'h0bad_f00d, host_data_o);
      repeat (40) @(posedge mclk);
      chk("burst_wait", 1, host_data_oe);
      ready_return_n <= 1;
      n = 0;
      do begin @(posedge mclk); n++; end while (host_data_oe !== 1'b0 && n < 200);
      chk("burst_done", 0, host_data_oe);
      lclk_run <= 0;
      data_path_select_n <= 1;
   endtask
   task test_data_path;
      data_path_select_n <= 0;
      host_byte_lane_n <= 4'b1110;
      apb(1, `REG_PTR, 5);
      host_cycle(1, 32'ha5a5_1234);
      host_cycle(1, 32'h0bad_f00d);
      chk("dp_write0", 32'ha5a5_1234, sram_model_inst.mem[5]);
      chk("dp_write1", 32'h0bad_f00d, sram_model_inst.mem[6]);
      chk("host_not_rx", 0, sram_model_inst.last_rx);
      apb(1, `REG_PTR, 5);
      host_cycle(0, 0);
      chk("dp_read", 32'ha5a5_1234, rd);
      apb(0, `REG_PTR, 0);
      chk("ptr_step", 6, rd);
      data_path_select_n <= 1;
   endtask
   task test_rx_status;
      int n;
      apb(1, `REG_CONFIG, 3'h4);
      apb(1, `REG_IRQ_ENABLE, 0);
      @(posedge mclk);
      rx_status_valid <= 1;
      n = 0;
      do begin @(posedge mclk); n++; end while (rx_ready !== 1'b1 && n < 50);
      rx_status_valid <= 0;
      n = 0;
      do begin @(posedge mclk); n++; end while (rx_buffer_write_active !== 1'b1 && n < 50);
      chk("rx_flag", 1, rx_buffer_write_active);
      chk("status_index", 0, ram_addr);
      chk("low_byte_float", 0, ram_data_oe[0]);
      repeat (10) @(posedge mclk);
      chk("status_word", 32'h1234_5aff, sram_model_inst.mem[0]);
      apb(0, `REG_IRQ_STATUS, 0);
      chk("irq_status", 1, rd[0]);
      chk("irq_masked", 0, irq_outputs[0]);
      apb(1, `REG_IRQ_ENABLE, 1);
      @(posedge mclk);
      chk("irq_raised", 1, irq_outputs[0]);
      apb(1, `REG_IRQ_CLEAR, 3);
      @(posedge mclk);
      chk("irq_cleared", 0, irq_outputs[0]);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1;
      @(posedge mclk);
      test_reset_and_mode();
      test_irq_select();
      test_decode();
      test_data_path();
      test_sync_cycles();
      test_rx_status();
      print_verdict();
   end
endmodule // host_bus_port_tb
